// [design/dual_timer_event_counter.sv]
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module dual_timer_event_counter #(
  parameter bit PFD_SRC_C1 = 1'b0
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [1:0] CNT_PIN,
  output logic [1:0] IRQ,
  output logic WAKE,
  output logic PORT_A_BIT3
);
  import tec_pkg::*;

  // ==========================================================
  // Shared state
  logic [7:0] control [2];
  logic [7:0] count [2];
  logic [7:0] preload [2];
  logic [7:0] irq_control_a;
  logic [7:0] irq_control_b;
  logic [7:0] port_a;
  logic [6:0] prescale;
  logic [1:0] div4;
  logic [1:0] sync1, sync2, sync3, level;
  logic [1:0] ovf;
  logic [1:0] hw_clear_run;
  logic [1:0] prescaled_clock;
  logic freq_divider_out;
  logic [7:0] next_rdata;

  // ==========================================================
  // Internal clock sources
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      prescale <= '0;
      div4 <= '0;
    end else begin
      prescale <= prescale + 7'h01;
      div4 <= div4 + 2'h1;
    end
  end

  // Tick when all prescaler bits below the selected stage are ones
  always_comb begin
    logic [2:0] rate;
    logic [7:0] low_mask;
    rate = control[0][RATE_LSB +: 3];
    low_mask = (8'h01 << rate) - 8'h01;
    prescaled_clock[0] = ((prescale & low_mask[6:0]) == low_mask[6:0]);
    prescaled_clock[1] = (div4 == C1_DIV_LAST);
  end

  // ==========================================================
  // Pin synchronisers, change accepted once stages two and three agree
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      level <= '0;
    end else begin
      sync1 <= CNT_PIN;
      sync2 <= sync1;
      sync3 <= sync2;
      // Hold the last agreed level while the two late stages differ
      level <= (sync2 == sync3) ? sync2 : level;
    end
  end

  // ==========================================================
  // Counters
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_cnt
      logic prev;
      logic armed;
      logic busy;
      logic [1:0] mode;
      logic run;
      logic active_edge;
      logic return_edge;
      logic tick;
      logic read_block;
      logic is_val_wr;
      logic [7:0] val_addr;
      assign val_addr = (g == 0) ? ADDR_C0_VALUE : ADDR_C1_VALUE;
      assign mode = control[g][MODE_LSB +: 2];
      assign run = control[g][RUN_BIT];
      // Edge select 0 means low-to-high
      assign active_edge = control[g][EDGE_BIT] ?
        (prev & ~level[g]) : (~prev & level[g]);
      assign return_edge = control[g][EDGE_BIT] ?
        (~prev & level[g]) : (prev & ~level[g]);
      assign read_block = RD && (ADDR == val_addr);
      assign is_val_wr = WR && (ADDR == val_addr);
      always_comb begin
        unique case (mode)
          MODE_EVENT: tick = active_edge;
          MODE_TIMER: tick = prescaled_clock[g];
          MODE_PULSE: tick = busy && prescaled_clock[g];
          default: tick = 1'b0;
        endcase
      end

      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          prev <= 1'b0;
        end else begin
          prev <= level[g];
        end
      end

      // Pulse measurement: armed by run, busy between the two edges
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          busy <= 1'b0;
          armed <= 1'b0;
        end else if (mode != MODE_PULSE || !run) begin
          // Arm while idle so that setting run starts one measurement
          busy <= 1'b0;
          armed <= 1'b1;
        end else if (busy && return_edge) begin
          busy <= 1'b0;
          armed <= 1'b0;
        end else if (armed && !busy && active_edge) begin
          busy <= 1'b1;
        end
      end
      // Completed measurement clears run; armed returns high once run is low
      assign hw_clear_run[g] = (mode == MODE_PULSE) && busy &&
        return_edge;

      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          count[g] <= '0;
          preload[g] <= '0;
          ovf[g] <= 1'b0;
        end else begin
          ovf[g] <= 1'b0;
          if (is_val_wr) begin
            preload[g] <= WDATA;
          end
          if (is_val_wr && !run) begin
            count[g] <= WDATA;
          end else if (run && tick && !read_block) begin
            if (count[g] == 8'hff) begin
              // Reload takes the old preload when a write coincides
              count[g] <= preload[g];
              ovf[g] <= 1'b1;
            end else begin
              count[g] <= count[g] + 8'h01;
            end
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Register writes
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      control[0] <= CTRL_RESET;
      control[1] <= CTRL_RESET;
    end else begin
      if (WR && ADDR == ADDR_C0_CONTROL) begin
        control[0] <= WDATA & C0_CTRL_MASK;
      end else if (hw_clear_run[0]) begin
        control[0][RUN_BIT] <= 1'b0;
      end
      if (WR && ADDR == ADDR_C1_CONTROL) begin
        control[1] <= WDATA & C1_CTRL_MASK;
      end else if (hw_clear_run[1]) begin
        control[1][RUN_BIT] <= 1'b0;
      end
    end
  end

  // Overflow flags: set wins over a software clear
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irq_control_a <= '0;
      irq_control_b <= '0;
    end else begin
      if (WR && ADDR == ADDR_IRQ_CONTROL_A) begin
        irq_control_a <= WDATA;
      end
      if (WR && ADDR == ADDR_IRQ_CONTROL_B) begin
        irq_control_b <= WDATA & 8'h77;
      end
      if (ovf[0]) begin
        irq_control_a[C0_FLAG_BIT] <= 1'b1;
      end
      if (ovf[1]) begin
        irq_control_b[C1_FLAG_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      port_a <= PORT_A_RESET;
    end else if (WR && ADDR == ADDR_PORT_A) begin
      port_a <= WDATA;
    end
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      freq_divider_out <= 1'b0;
    end else if (ovf[PFD_SRC_C1]) begin
      freq_divider_out <= ~freq_divider_out;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PORT_A_BIT3 <= 1'b0;
      WAKE <= 1'b0;
      IRQ <= '0;
    end else begin
      PORT_A_BIT3 <= port_a[PA_PFD_BIT] & freq_divider_out;
      WAKE <= |ovf;
      IRQ[0] <= irq_control_a[C0_FLAG_BIT] &
        irq_control_a[C0_IEN_BIT];
      IRQ[1] <= irq_control_b[C1_FLAG_BIT] &
        irq_control_b[C1_IEN_BIT];
    end
  end

  always_comb begin
    unique case (ADDR)
      ADDR_C0_VALUE: next_rdata = count[0];
      ADDR_C0_CONTROL: next_rdata = control[0];
      ADDR_C1_VALUE: next_rdata = count[1];
      ADDR_C1_CONTROL: next_rdata = control[1];
      ADDR_IRQ_CONTROL_A: next_rdata = irq_control_a;
      ADDR_IRQ_CONTROL_B: next_rdata = irq_control_b;
      ADDR_PORT_A: next_rdata = port_a;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RDATA <= '0;
    end else begin
      RDATA <= RD ? next_rdata : 8'h00;
    end
  end

  // ==========================================================
  // Checks
  a_ctrl_bit5_zero: assert property (@(posedge CLK) disable iff (RST)
    RD && ADDR == ADDR_C0_CONTROL |=> RDATA[5] == 1'b0)
    else $error("control bit 5 not zero");
  a_c1_low_zero: assert property (@(posedge CLK) disable iff (RST)
    control[1][2:0] == 3'h0 && control[1][5] == 1'b0)
    else $error("counter 1 unused bits set");
  a_stopped_load: assert property (@(posedge CLK) disable iff (RST)
    WR && ADDR == ADDR_C0_VALUE && !control[0][RUN_BIT]
    |=> count[0] == $past(WDATA))
    else $error("stopped write did not load counter");
  a_preload_store: assert property (@(posedge CLK) disable iff (RST)
    WR && ADDR == ADDR_C1_VALUE |=> preload[1] == $past(WDATA))
    else $error("preload not stored");
  a_ovf_flag: assert property (@(posedge CLK) disable iff (RST)
    ovf[0] |=> irq_control_a[C0_FLAG_BIT])
    else $error("overflow flag not set");
  a_ovf_reload: assert property (@(posedge CLK) disable iff (RST)
    $rose(ovf[1]) |-> count[1] == $past(preload[1]))
    else $error("overflow did not reload");
  a_wake_follow: assert property (@(posedge CLK) disable iff (RST)
    |ovf |=> WAKE)
    else $error("wake missing after overflow");
  a_irq_gate: assert property (@(posedge CLK) disable iff (RST)
    !irq_control_b[C1_IEN_BIT] |=> !IRQ[1])
    else $error("interrupt passed while disabled");
  a_read_hold: assert property (@(posedge CLK) disable iff (RST)
    RD && ADDR == ADDR_C0_VALUE && !WR |=> count[0] == $past(count[0]))
    else $error("counter moved during read");
  a_timer_div4: assert property (@(posedge CLK) disable iff (RST)
    control[1][MODE_LSB +: 2] == MODE_TIMER && control[1][RUN_BIT] &&
    !WR && !RD && count[1] != 8'hff && div4 == 2'h3
    ##1 !WR && !RD |-> count[1] == $past(count[1]) + 8'h01)
    else $error("counter 1 timer tick missing");
  c_overflow: cover property (@(posedge CLK) disable iff (RST) ovf[0]);
  c_pulse_done: cover property (@(posedge CLK) disable iff (RST)
    hw_clear_run[1]);
  c_pfd_toggle: cover property (@(posedge CLK) disable iff (RST)
    $rose(PORT_A_BIT3));
  c_pulse_start: cover property (@(posedge CLK) disable iff (RST)
    $rose(g_cnt[0].busy));
  c_wake: cover property (@(posedge CLK) disable iff (RST) WAKE);

  // ==========================================================
  // Further checks on control bits, counting, flags, outputs and synchronisers
  a_c0_bit5_store: assert property (@(posedge CLK) disable iff (RST)
    control[0][5] == 1'b0)
    else $error("counter 0 bit 5 set");
  a_hw_run_clear: assert property (@(posedge CLK) disable iff (RST)
    hw_clear_run[0] && !(WR && ADDR == ADDR_C0_CONTROL)
    |=> !control[0][RUN_BIT])
    else $error("run not cleared after measurement");
  a_run_kept: assert property (@(posedge CLK) disable iff (RST)
    control[0][MODE_LSB +: 2] != MODE_PULSE && control[0][RUN_BIT] &&
    !(WR && ADDR == ADDR_C0_CONTROL) |=> control[0][RUN_BIT])
    else $error("run cleared by hardware");
  a_event_step: assert property (@(posedge CLK) disable iff (RST)
    control[0][MODE_LSB +: 2] == MODE_EVENT && control[0][RUN_BIT] &&
    g_cnt[0].active_edge && !WR && !RD && count[0] != 8'hff
    |=> count[0] == $past(count[0]) + 8'h01)
    else $error("event not counted");
  a_stopped_hold: assert property (@(posedge CLK) disable iff (RST)
    !control[0][RUN_BIT] && !WR |=> count[0] == $past(count[0]))
    else $error("stopped counter moved");
  a_running_write: assert property (@(posedge CLK) disable iff (RST)
    WR && ADDR == ADDR_C1_VALUE && control[1][RUN_BIT] &&
    !g_cnt[1].tick |=> count[1] == $past(count[1]))
    else $error("running write loaded counter");
  a_pulse_idle: assert property (@(posedge CLK) disable iff (RST)
    control[0][MODE_LSB +: 2] == MODE_PULSE && !g_cnt[0].busy && !WR
    |=> count[0] == $past(count[0]))
    else $error("pulse result disturbed");
  a_c1_flag: assert property (@(posedge CLK) disable iff (RST)
    ovf[1] |=> irq_control_b[C1_FLAG_BIT])
    else $error("counter 1 flag not set");
  a_pfd_toggle: assert property (@(posedge CLK) disable iff (RST)
    ovf[PFD_SRC_C1] |=> freq_divider_out != $past(freq_divider_out))
    else $error("divider did not toggle");
  a_pfd_gate: assert property (@(posedge CLK) disable iff (RST)
    !port_a[PA_PFD_BIT] |=> !PORT_A_BIT3)
    else $error("divider output while disabled");
  a_irq0_gate: assert property (@(posedge CLK) disable iff (RST)
    !irq_control_a[C0_IEN_BIT] |=> !IRQ[0])
    else $error("counter 0 interrupt while disabled");
  a_irq1_level: assert property (@(posedge CLK) disable iff (RST)
    irq_control_b[C1_FLAG_BIT] && irq_control_b[C1_IEN_BIT] |=> IRQ[1])
    else $error("counter 1 interrupt missing");
  a_wake_only: assert property (@(posedge CLK) disable iff (RST)
    !(|ovf) |=> !WAKE)
    else $error("wake without overflow");
  a_rdata_idle: assert property (@(posedge CLK) disable iff (RST)
    !RD |=> RDATA == 8'h00)
    else $error("read data outside read cycle");
  a_c0_prescale: assert property (@(posedge CLK) disable iff (RST)
    control[0] == 8'h90 && !WR && !RD && count[0] != 8'hff
    |=> count[0] == $past(count[0]) + 8'h01)
    else $error("undivided tick missing");
  a_c1_div_gap: assert property (@(posedge CLK) disable iff (RST)
    control[1][MODE_LSB +: 2] == MODE_TIMER && div4 != C1_DIV_LAST &&
    !WR |=> count[1] == $past(count[1]))
    else $error("counter 1 ticked off the divider");
  a_c0_reload: assert property (@(posedge CLK) disable iff (RST)
    ovf[0] |-> count[0] == $past(preload[0]))
    else $error("counter 0 did not reload");
  a_edge_sync: assert property (@(posedge CLK) disable iff (RST)
    sync2 != sync3 |=> level == $past(level))
    else $error("level moved before stages agreed");
endmodule

// [pkg/tec_pkg.sv]
// Summary of operation
// - Two 8-bit up-counters, pin or internal clock
// - Counter 1 internal clock is system/4
// - Counter 0 prescaler divides 1 to 128
// - Value write stores preload, read gives count
// - Mode bits 7:6: event, timer, pulse width
// - Pulse mode counts internal ticks during level
// - Overflow past FFH reloads and sets flag
// - Pulse mode starts on edge, stops, clears run
// - Result holds until run set again
// - Pulse mode overflow also reloads and flags
// - Run bit 4; hardware clears only in pulse
// - Bit 3 selects rising or falling edge
// - Any overflow raises wake-up
// - Selected counter overflow drives divider output
// - Port A bit 3 enables divider output
// - Interrupt enable zero blocks interrupt request
// - Stopped write loads counter, running only preload
// - Reading value blocks that tick
// - Counter 1 control same layout, low bits zero
package tec_pkg;
  localparam logic [7:0] ADDR_C0_VALUE = 8'h0d;
  localparam logic [7:0] ADDR_C0_CONTROL = 8'h0e;
  localparam logic [7:0] ADDR_C1_VALUE = 8'h10;
  localparam logic [7:0] ADDR_C1_CONTROL = 8'h11;
  localparam logic [7:0] ADDR_IRQ_CONTROL_A = 8'h0b;
  localparam logic [7:0] ADDR_IRQ_CONTROL_B = 8'h1e;
  localparam logic [7:0] ADDR_PORT_A = 8'h12;
  localparam int EDGE_BIT = 3;
  localparam int RUN_BIT = 4;
  localparam int MODE_LSB = 6;
  localparam int RATE_LSB = 0;
  localparam int C0_FLAG_BIT = 6;
  localparam int C0_IEN_BIT = 2;
  localparam int C1_FLAG_BIT = 4;
  localparam int C1_IEN_BIT = 0;
  localparam int PA_PFD_BIT = 3;
  localparam logic [7:0] C0_CTRL_MASK = 8'hdf;
  localparam logic [7:0] C1_CTRL_MASK = 8'hd8;
  localparam logic [7:0] CTRL_RESET = 8'h08;
  localparam logic [7:0] PORT_A_RESET = 8'hff;
  localparam logic [1:0] C1_DIV_LAST = 2'h3;
  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_TIMER = 2'h2;
  localparam logic [1:0] MODE_PULSE = 2'h3;
endpackage

// [bench/pulse_source.sv]
`timescale 1ns/1ps
module pulse_source (
  input wire logic CLK,
  output logic [1:0] PIN
);
  initial PIN = 2'b00;
  // ==========================================
  // One level excursion, then a quiet spell
  // Excursion held n clocks, return level held 8 clocks
  task automatic pulse(input int ch, input logic lvl, input int n);
    @(posedge CLK);
    PIN[ch] <= lvl;
    repeat (n) @(posedge CLK);
    PIN[ch] <= ~lvl;
    repeat (8) @(posedge CLK);
  endtask
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import tec_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] d;
  logic [1:0] pins;
  logic [1:0] irq;
  logic wake;
  logic pa3;
  int err_count = 0;
  int total_checks = 0;
  int wakes = 0;
  always #2.5 clk = ~clk;
  dual_timer_event_counter i_dut (.CLK(clk), .RST(rst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .CNT_PIN(pins),
    .IRQ(irq), .WAKE(wake), .PORT_A_BIT3(pa3));
  pulse_source i_src (.CLK(clk), .PIN(pins));
  always @(posedge clk) begin
    if (wake) begin
      wakes++;
    end
  end
  // ==========================================
  // Bus and compare helpers
  task check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task expect_reg(input logic [7:0] a, input logic [7:0] exp);
    rd_reg(a);
    check(d, exp);
  endtask
  // Internal ticks land a cycle or two either side of the bus writes
  task near(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    rd_reg(a);
    check({7'h00, (d >= lo) && (d <= hi)}, 8'h01);
  endtask
  task conclude;
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #400000;
    err_count++;
    conclude();
  end
  // ==========================================
  // Test sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    expect_reg(ADDR_C0_CONTROL, CTRL_RESET);
    expect_reg(ADDR_C1_CONTROL, CTRL_RESET);
    expect_reg(ADDR_PORT_A, PORT_A_RESET);
    expect_reg(8'h00, 8'h00);
    wr_reg(ADDR_C0_CONTROL, 8'h2f);
    expect_reg(ADDR_C0_CONTROL, 8'h0f);
    wr_reg(ADDR_C1_CONTROL, 8'h2f);
    expect_reg(ADDR_C1_CONTROL, 8'h08);
    wr_reg(ADDR_C0_CONTROL, 8'h10);
    wr_reg(ADDR_C0_CONTROL, 8'h00);
    wr_reg(ADDR_C1_CONTROL, 8'h10);
    wr_reg(ADDR_C1_CONTROL, 8'h00);
    $display("test registers done");
    wr_reg(ADDR_IRQ_CONTROL_A, 8'h04);
    wr_reg(ADDR_C0_VALUE, 8'hfd);
    expect_reg(ADDR_C0_VALUE, 8'hfd);
    wr_reg(ADDR_C0_CONTROL, 8'h50);
    wr_reg(ADDR_C0_VALUE, 8'h10);
    expect_reg(ADDR_C0_VALUE, 8'hfd);
    i_src.pulse(0, 1'b1, 6);
    i_src.pulse(0, 1'b1, 6);
    expect_reg(ADDR_C0_VALUE, 8'hff);
    i_src.pulse(0, 1'b1, 6);
    expect_reg(ADDR_C0_VALUE, 8'h10);
    expect_reg(ADDR_IRQ_CONTROL_A, 8'h44);
    check({7'h00, irq[0]}, 8'h01);
    check({7'h00, pa3}, 8'h01);
    expect_reg(ADDR_C0_CONTROL, 8'h50);
    wr_reg(ADDR_IRQ_CONTROL_A, 8'h40);
    repeat (2) @(posedge clk);
    check({7'h00, irq[0]}, 8'h00);
    wr_reg(ADDR_PORT_A, 8'hf7);
    repeat (2) @(posedge clk);
    check({7'h00, pa3}, 8'h00);
    wr_reg(ADDR_IRQ_CONTROL_A, 8'h00);
    check(8'(wakes), 8'h01);
    $display("test event count done");
    for (int k = 0; k < 8; k++) begin
      wr_reg(ADDR_C0_CONTROL, 8'h00);
      wr_reg(ADDR_C0_VALUE, 8'h00);
      wr_reg(ADDR_C0_CONTROL, 8'h90 | 8'(k));
      repeat (32 << k) @(posedge clk);
      wr_reg(ADDR_C0_CONTROL, 8'h00);
      near(ADDR_C0_VALUE, 8'd30, 8'd35);
    end
    wr_reg(ADDR_C1_VALUE, 8'h00);
    wr_reg(ADDR_C1_CONTROL, 8'h90);
    repeat (128) @(posedge clk);
    wr_reg(ADDR_C1_CONTROL, 8'h00);
    near(ADDR_C1_VALUE, 8'd30, 8'd35);
    $display("test timer rates done");
    wr_reg(ADDR_C0_VALUE, 8'h00);
    wr_reg(ADDR_C0_CONTROL, 8'hd0);
    i_src.pulse(0, 1'b1, 40);
    near(ADDR_C0_VALUE, 8'd38, 8'd42);
    expect_reg(ADDR_C0_CONTROL, 8'hc0);
    i_src.pulse(0, 1'b1, 20);
    near(ADDR_C0_VALUE, 8'd38, 8'd42);
    // Idle the counter 1 input high so its falling edge is the start
    i_src.pulse(1, 1'b0, 4);
    wr_reg(ADDR_C1_VALUE, 8'h00);
    wr_reg(ADDR_C1_CONTROL, 8'hd8);
    i_src.pulse(1, 1'b0, 40);
    near(ADDR_C1_VALUE, 8'd8, 8'd12);
    expect_reg(ADDR_C1_CONTROL, 8'hc8);
    $display("test pulse width done");
    conclude();
  end
endmodule
